/* File: inc/fsoc_pkg.sv */
/*
 * Shared constants and carrier types for the fan-out serial configuration block.
 * Assumes a SystemVerilog compiler; no other file is needed before this one.
 */
package fsoc_pkg;

    // Geometry of the configuration word
    localparam int unsigned NUM_OUTPUTS   = 10;
    localparam int unsigned CFG_WIDTH     = 11;
    localparam int unsigned SEL_BIT       = 10;
    localparam int unsigned LOAD_PULSE    = 12;
    localparam int unsigned CNT_WIDTH     = 4;

    // Reset values
    localparam logic [10:0] SHIFT_RESET   = 11'h000;
    localparam logic [10:0] CTRL_RESET    = 11'h000;
    localparam logic [9:0]  ALL_ENABLED   = 10'h3FF;

    // Shift clock ceiling the controller must respect
    localparam int unsigned SHIFT_FMAX_MHZ = 100;

    // Configuration sequencer states
    typedef enum logic [1:0] {
        FSOC_IDLE,
        FSOC_SHIFT,
        FSOC_LOCKED
    } fsoc_state_t;

    // Effective fan-out setting seen by the output stage
    typedef struct packed {
        logic        select_b;
        logic [9:0]  pair_enable;
    } fsoc_cfg_t;

endpackage : fsoc_pkg

/* File: rtl/fsoc_sync.sv */
/*
 * Two-flop level synchroniser.
 * Assumes the input is a quasi-static level from another clock domain or a pin.
 */
`timescale 1ns/1ns
module fsoc_sync
    import fsoc_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule : fsoc_sync

/* File: rtl/fsoc_outmux.sv */
/*
 * Output stage: picks the input clock and gates each differential pair.
 * Assumes the configuration word is stable, coming from system-clock flops.
 */
`timescale 1ns/1ns
module fsoc_outmux
    import fsoc_pkg::*;
#(
    parameter int unsigned N = NUM_OUTPUTS
) (
    // Clock sources
    input  wire logic          clock_input_a,
    input  wire logic          clock_input_b,
    // Setting
    input  wire fsoc_cfg_t     cfg,
    // Pairs
    output logic [N-1:0]       pair_p,
    output logic [N-1:0]       pair_n,
    output logic [N-1:0]       pair_oe_n
);

    logic sel_clk;

    // Input selection, 0 gives input A
    assign sel_clk = cfg.select_b ? clock_input_b : clock_input_a;

    // One pair per bit; disabled pairs are released for high impedance
    for (genvar i = 0; i < N; i++) begin : g_pair
        assign pair_p[i]    = cfg.pair_enable[i] & sel_clk;
        assign pair_n[i]    = cfg.pair_enable[i] & ~sel_clk;
        assign pair_oe_n[i] = ~cfg.pair_enable[i];
    end

endmodule : fsoc_outmux

/* File: rtl/fsoc_top.sv */
/*
 * Serial configuration logic of a ten-pair clock fan-out buffer.
 * A controller shifts an 11-bit word in on config_shift_clock while
 * program_enable is high; the twelfth edge loads the control register.
 * Assumes clk_sys is free running; config_shift_clock runs only when the
 * controller programs, so the link domain keeps its own state and the
 * system domain only sees synchronised levels.
 */
`timescale 1ns/1ns
module fsoc_top
    import fsoc_pkg::*;
(
    // System clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    // Serial configuration pins
    input  wire logic                   config_shift_clock,
    input  wire logic                   serial_config_in,
    input  wire logic                   program_enable,
    // Clock inputs
    input  wire logic                   clock_input_a,
    input  wire logic                   clock_input_b,
    // Output pairs, enable low while driving
    output logic [NUM_OUTPUTS-1:0]      pair_p,
    output logic [NUM_OUTPUTS-1:0]      pair_n,
    output logic [NUM_OUTPUTS-1:0]      pair_oe_n,
    // Status
    output logic                        programmed,
    output logic [CFG_WIDTH-1:0]        control_word
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: shift register, pulse counter, control register
    ////////////////////////////////////////////////////////////////////////

    logic [CFG_WIDTH-1:0] shift_reg;
    logic [CFG_WIDTH-1:0] ctrl_reg;
    logic [CNT_WIDTH-1:0] pulse_cnt;
    logic                 ctrl_valid;
    fsoc_state_t          state;
    logic                 link_rst_n;
    logic [1:0]           link_rst_sync;

    // The link clock can be idle, so system reset is released into it
    // through its own two flops rather than relying on free edges.
    always_ff @(posedge config_shift_clock or negedge resetn) begin
        if (!resetn) begin
            link_rst_sync <= 2'h0;
        end else begin
            link_rst_sync <= {link_rst_sync[0], 1'b1};
        end
    end
    assign link_rst_n = link_rst_sync[1];

    // Sequencer: counts edges, loads once, then locks until reset or until program_enable goes low
    always_ff @(posedge config_shift_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state     <= FSOC_IDLE;
            pulse_cnt <= '0;
        end else if (!program_enable) begin
            state     <= FSOC_IDLE;
            pulse_cnt <= '0;
        end else begin
            case (state)
                FSOC_IDLE: begin
                    state     <= FSOC_SHIFT;
                    pulse_cnt <= CNT_WIDTH'(1);
                end
                FSOC_SHIFT: begin
                    if (pulse_cnt == CNT_WIDTH'(LOAD_PULSE - 1)) begin
                        state <= FSOC_LOCKED;
                    end
                    pulse_cnt <= pulse_cnt + CNT_WIDTH'(1);
                end
                FSOC_LOCKED: begin
                    state <= FSOC_LOCKED;
                end
                default: begin
                    state     <= FSOC_IDLE;
                    pulse_cnt <= '0;
                end
            endcase
        end
    end

    // Shift register: new bit enters the top stage, others move down,
    // so the first bit presented ends in bit 0 after eleven edges
    always_ff @(posedge config_shift_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            shift_reg <= SHIFT_RESET;
        end else if (!program_enable) begin
            shift_reg <= SHIFT_RESET;
        end else if (state != FSOC_LOCKED &&
                     !(state == FSOC_SHIFT && pulse_cnt == CNT_WIDTH'(LOAD_PULSE - 1))) begin
            shift_reg <= {serial_config_in, shift_reg[CFG_WIDTH-1:1]};
        end
    end

    // Control register: loaded on the twelfth edge, only once
    always_ff @(posedge config_shift_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            ctrl_reg   <= CTRL_RESET;
            ctrl_valid <= 1'b0;
        end else if (!program_enable) begin
            ctrl_reg   <= CTRL_RESET;
            ctrl_valid <= 1'b0;
        end else if (state == FSOC_SHIFT &&
                     pulse_cnt == CNT_WIDTH'(LOAD_PULSE - 1)) begin
            ctrl_reg   <= shift_reg;
            ctrl_valid <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossing into the system domain
    ////////////////////////////////////////////////////////////////////////

    logic [CFG_WIDTH-1:0] ctrl_sys;
    logic                 valid_sys;
    logic                 pe_sys;
    logic                 si_sys;

    // Control word is static once loaded, and qualified by a valid level
    // that is synchronised one flop behind it, so no torn word is used.
    fsoc_sync #(.WIDTH(CFG_WIDTH)) u_sync_word (
        .clk   (clk_sys),
        .rst_n (resetn),
        .din   (ctrl_reg),
        .dout  (ctrl_sys)
    );

    logic valid_d;
    fsoc_sync #(.WIDTH(3)) u_sync_pins (
        .clk   (clk_sys),
        .rst_n (resetn),
        .din   ({ctrl_valid, program_enable, serial_config_in}),
        .dout  ({valid_d, pe_sys, si_sys})
    );

    // Extra delay on valid covers word settling across the sync
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            valid_sys <= 1'b0;
        end else begin
            valid_sys <= valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective configuration
    ////////////////////////////////////////////////////////////////////////

    fsoc_cfg_t next_cfg;
    fsoc_cfg_t cfg;

    // Bit k of the word drives pair 9-k; bit 10 picks the input
    always_comb begin
        next_cfg.select_b    = si_sys;
        next_cfg.pair_enable = ALL_ENABLED;
        if (pe_sys && valid_sys) begin
            next_cfg.select_b = ctrl_sys[SEL_BIT];
            for (int k = 0; k < NUM_OUTPUTS; k++) begin
                next_cfg.pair_enable[NUM_OUTPUTS-1-k] = ctrl_sys[k];
            end
        end else if (pe_sys) begin
            next_cfg.select_b = 1'b0;
        end
    end

    // Registered setting, default is all pairs on and input A
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfg.select_b    <= 1'b0;
            cfg.pair_enable <= ALL_ENABLED;
            programmed      <= 1'b0;
            control_word    <= CTRL_RESET;
        end else begin
            cfg          <= next_cfg;
            programmed   <= pe_sys & valid_sys;
            control_word <= valid_sys ? ctrl_sys : CTRL_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output stage
    ////////////////////////////////////////////////////////////////////////

    fsoc_outmux #(.N(NUM_OUTPUTS)) u_outmux (
        .clock_input_a (clock_input_a),
        .clock_input_b (clock_input_b),
        .cfg           (cfg),
        .pair_p        (pair_p),
        .pair_n        (pair_n),
        .pair_oe_n     (pair_oe_n)
    );

endmodule : fsoc_top

/* File: tb/fsoc_monitor.sv */
/* Port checker for fsoc_top: pair gating, enable map, standard mode.
   Assumes it is bound into fsoc_top by the bind after endmodule. */
`timescale 1ns/1ns
module fsoc_monitor
    import fsoc_pkg::*;
(
    // Clock, reset and pins
    input wire logic                   clk_sys,
    input wire logic                   resetn,
    input wire logic                   serial_config_in,
    input wire logic                   program_enable,
    input wire logic                   clock_input_a,
    input wire logic                   clock_input_b,
    // Watched outputs
    input wire logic [NUM_OUTPUTS-1:0] pair_p,
    input wire logic [NUM_OUTPUTS-1:0] pair_n,
    input wire logic [NUM_OUTPUTS-1:0] pair_oe_n,
    input wire logic                   programmed,
    input wire logic [CFG_WIDTH-1:0]   control_word
);
    logic [NUM_OUTPUTS-1:0] off_map;
    logic [NUM_OUTPUTS-1:0] sel_clk;
    // Word bit k gates pair 9-k
    always_comb begin
        for (int k = 0; k < NUM_OUTPUTS; k++) begin
            off_map[NUM_OUTPUTS-1-k] = ~control_word[k];
        end
    end
    assign sel_clk = {NUM_OUTPUTS{control_word[SEL_BIT] ? clock_input_b : clock_input_a}};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Settling windows cover the synchroniser latency
    sequence s_loaded; programmed[*5]; endsequence
    sequence s_std; (!program_enable && $stable(serial_config_in))[*6]; endsequence
    AST_RESET_VALUES: assert property ($rose(resetn) |-> pair_oe_n == '0 && control_word == '0)
        else $error("reset values wrong");
    AST_ENABLE_MAP: assert property (s_loaded |-> pair_oe_n == off_map)
        else $error("pair enable map wrong");
    AST_PAIR_CLOCK: assert property (s_loaded |-> ((pair_p ^ sel_clk) & ~pair_oe_n) == '0)
        else $error("enabled pair not on selected clock");
    AST_OFF_QUIET: assert property (((pair_p | pair_n) & pair_oe_n) == '0)
        else $error("disabled pair driven");
    AST_PAIR_DIFF: assert property (((pair_p ~^ pair_n) & ~pair_oe_n) == '0)
        else $error("pair legs not complementary");
    AST_STD_ALL_ON: assert property (s_std |-> pair_oe_n == '0 && !programmed)
        else $error("standard mode not all enabled");
    AST_STD_SELECT: assert property (s_std |-> pair_p == {NUM_OUTPUTS{serial_config_in ? clock_input_b : clock_input_a}})
        else $error("standard mode select wrong");
    AST_LOAD_ONCE: assert property (programmed && $past(programmed) |-> $stable(control_word))
        else $error("control word changed after load");
endmodule : fsoc_monitor
bind fsoc_top fsoc_monitor fsoc_monitor_i (.clk_sys, .resetn, .serial_config_in, .program_enable,
    .clock_input_a, .clock_input_b, .pair_p, .pair_n, .pair_oe_n, .programmed, .control_word);

/* File: tb/fsoc_host.sv */
/* Host controller model for the serial configuration pins.
   Assumes the bench calls one task at a time. */
`timescale 1ns/1ns
module fsoc_host
    import fsoc_pkg::*;
(
    // Configuration pins
    output logic config_shift_clock,
    output logic serial_config_in,
    output logic program_enable
);
    // Idle at the pin pulls: clock high, data and enable low
    initial begin
        config_shift_clock = 1'b1;
        serial_config_in   = 1'b0;
        program_enable     = 1'b0;
    end
    // 12 ns cycle stays under the shift ceiling; data moves 2 ns after the edge for hold
    task automatic pulse(input logic d);
        #2 serial_config_in = d;
        #4 config_shift_clock = 1'b0;
        #6 config_shift_clock = 1'b1;
    endtask : pulse
    // Clears the sequencer so a new load is accepted
    task automatic reset_pulse();
        #3 program_enable = 1'b0;
        repeat (3) pulse(1'b0);
    endtask : reset_pulse
    // Bit 0 first; the pulse after the eleventh loads
    task automatic load(input logic [CFG_WIDTH-1:0] w, input int n);
        // Enable moves off the last reset edge, which must still see it low
        #3 program_enable = 1'b1;
        for (int i = 0; i < n; i++) begin
            pulse(i < CFG_WIDTH ? w[i] : 1'b0);
        end
        #2 serial_config_in = 1'b0;
    endtask : load
    // Standard mode: data pin level picks the input
    task automatic standard(input logic sel);
        #3 program_enable = 1'b0;
        serial_config_in = sel;
    endtask : standard
endmodule : fsoc_host

/* File: tb/fsoc_top_tb_top.sv */
/* Self-checking bench for fsoc_top with a host model on the serial pins.
   Assumes package, design, monitor and host are compiled first. */
`timescale 1ns/1ns
module fsoc_top_tb_top
    import fsoc_pkg::*;
;
    logic                   clk_sys = 1'b0;
    logic                   resetn  = 1'b0;
    logic                   ck_a    = 1'b0;
    logic                   ck_b    = 1'b0;
    wire logic              cfg_clk;
    wire logic              cfg_si;
    wire logic              cfg_en;
    logic [NUM_OUTPUTS-1:0] pair_p;
    logic [NUM_OUTPUTS-1:0] pair_n;
    logic [NUM_OUTPUTS-1:0] pair_oe_n;
    logic                   programmed;
    logic [CFG_WIDTH-1:0]   control_word;
    int                     errors      = 0;
    int                     comparisons = 0;
    int                     cycles      = 0;
    fsoc_host fsoc_host_i (.config_shift_clock(cfg_clk), .serial_config_in(cfg_si), .program_enable(cfg_en));
    fsoc_top fsoc_top_i (.clk_sys, .resetn, .config_shift_clock(cfg_clk), .serial_config_in(cfg_si),
        .program_enable(cfg_en), .clock_input_a(ck_a), .clock_input_b(ck_b), .pair_p, .pair_n,
        .pair_oe_n, .programmed, .control_word);
    always #20 clk_sys = ~clk_sys;
    // Two inputs in opposite phase so a wrong select shows
    always @(posedge clk_sys) begin
        ck_a <= ~ck_a;
        ck_b <= ck_a;
    end
    // Hang guard, far above the roughly 180 cycles needed
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            finish_test();
        end
    end
    task automatic check(input logic [CFG_WIDTH-1:0] seen, input logic [CFG_WIDTH-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Answer lands within 5 edges; sample mid-cycle
    task automatic check_pairs(input logic [NUM_OUTPUTS-1:0] oe, input logic sel);
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        check({1'b0, pair_oe_n}, {1'b0, oe});
        check({1'b0, pair_p}, {1'b0, {NUM_OUTPUTS{sel ? ck_b : ck_a}} & ~oe});
        check({1'b0, pair_n}, {1'b0, {NUM_OUTPUTS{sel ? ~ck_b : ~ck_a}} & ~oe});
    endtask : check_pairs
    // Reset held 20 cycles, then the link reset pulses
    task automatic t_defaults();
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        fsoc_host_i.reset_pulse();
        check_pairs('0, 1'b0);
        check(control_word, '0);
        check({10'h000, programmed}, 11'h000);
    endtask : t_defaults
    task automatic t_program(input logic [CFG_WIDTH-1:0] w);
        logic [NUM_OUTPUTS-1:0] oe;
        for (int k = 0; k < NUM_OUTPUTS; k++) oe[NUM_OUTPUTS-1-k] = ~w[k];
        fsoc_host_i.reset_pulse();
        fsoc_host_i.load(w, 12);
        check_pairs(oe, w[SEL_BIT]);
        check(control_word, w);
        check({10'h000, programmed}, 11'h001);
    endtask : t_program
    // Second load without reset must be ignored
    task automatic t_refuse();
        t_program(11'h35A);
        fsoc_host_i.load(11'h4A5, 12);
        check_pairs(10'h294, 1'b0);
        check(control_word, 11'h35A);
    endtask : t_refuse
    // Eleven pulses only: no load yet
    task automatic t_short();
        fsoc_host_i.reset_pulse();
        fsoc_host_i.load(11'h4F0, 11);
        check_pairs('0, 1'b0);
        check({10'h000, programmed}, 11'h000);
    endtask : t_short
    task automatic t_standard(input logic sel);
        t_program(11'h2C3);
        fsoc_host_i.reset_pulse();
        fsoc_host_i.standard(sel);
        check_pairs('0, sel);
        check(control_word, '0);
        check({10'h000, programmed}, 11'h000);
    endtask : t_standard
    task automatic finish_test();
        if (errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    initial begin
        t_defaults();
        t_program(11'h4A5);
        t_program(11'h35A);
        t_program(11'h7FF);
        t_program(11'h000);
        t_refuse();
        t_short();
        t_standard(1'b1);
        t_standard(1'b0);
        t_program(11'h5B6);
        t_defaults();
        finish_test();
    end
endmodule : fsoc_top_tb_top
